// [rtl/port_output_disable_ctrl.sv]
// output stop controller for timer pwm pins with axi4-lite registers
`timescale 1ns/100ps
module port_output_disable_ctrl
  import stop_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // axi4-lite write
  input  wire logic         awvalid,
  output logic              awready,
  input  wire logic [7:0]   awaddr,
  input  wire logic [2:0]   awprot,
  input  wire logic         wvalid,
  output logic              wready,
  input  wire logic [31:0]  wdata,
  input  wire logic [3:0]   wstrb,
  output logic              bvalid,
  input  wire logic         bready,
  output logic [1:0]        bresp,
  // axi4-lite read
  input  wire logic         arvalid,
  output logic              arready,
  input  wire logic [7:0]   araddr,
  input  wire logic [2:0]   arprot,
  output logic              rvalid,
  input  wire logic         rready,
  output logic [31:0]       rdata,
  output logic [1:0]        rresp,
  // active-low stop request inputs
  input  wire logic         stop_req_in_0,
  input  wire logic         stop_req_in_4,
  input  wire logic         stop_req_in_8,
  input  wire logic         stop_req_in_9,
  input  wire logic         stop_req_in_10,
  input  wire logic         stop_req_in_11,
  input  wire logic         stop_req_in_12,
  input  wire logic         stop_req_in_13,
  input  wire logic         stop_req_in_14,
  // monitored sources
  input  wire pwm_levels_s  pwm_levels,
  input  wire logic         osc_stopped,
  input  wire logic         analog_comparator,
  // pin control and interrupt requests
  output logic              pin_stop,
  output logic              port_mode,
  output logic              irq_input,
  output logic              irq_output
);

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // sampling tick of a level mode; prohibited codes never sample
  function automatic logic level_tick(input logic [3:0] mode, input logic [6:0] div);
    logic [6:0] msk;
    logic       ok;
    msk = MSK_DIV1;
    ok  = 1'b1;
    case (mode)
      MODE_DIV1:   msk = MSK_DIV1;
      MODE_DIV2:   msk = MSK_DIV2;
      MODE_DIV4:   msk = MSK_DIV4;
      MODE_DIV8:   msk = MSK_DIV8;
      MODE_DIV16:  msk = MSK_DIV16;
      MODE_DIV128: msk = MSK_DIV128;
      default:     ok  = 1'b0;
    endcase
    return ok && ((div & msk) == msk);
  endfunction : level_tick

  // required run of low samples
  function automatic logic [4:0] run_need(input logic [3:0] sel);
    case (sel)
      SCNT_SEL8: return RUN_8;
      SCNT_SEL4: return RUN_4;
      default:   return RUN_16;
    endcase
  endfunction : run_need

  //////////////////////////////////////////////////////////////////////////////
  // state

  state_s          s_r;
  state_s          s_nxt;
  logic [N_IN-1:0] req_n;
  logic            do_write;
  logic [5:0]      widx;
  logic [5:0]      ridx;
  logic [15:0]     wmask;
  logic [15:0]     wval;
  logic [N_IN-1:0] in_flags;

  assign req_n = {stop_req_in_14, stop_req_in_13, stop_req_in_12, stop_req_in_11, stop_req_in_10,
                  stop_req_in_9, stop_req_in_8, stop_req_in_4, stop_req_in_0};
  assign do_write = s_r.aw_got && s_r.w_got && !s_r.bvalid;
  assign widx     = s_r.awaddr[7:2];
  assign ridx     = araddr[7:2];
  assign wmask    = {{8{s_r.wstrb[1]}}, {8{s_r.wstrb[0]}}};
  assign wval     = s_r.wdata[15:0];

  always_comb begin
    for (int i = 0; i < N_IN; i++) begin
      in_flags[i] = s_r.ictl[i][FLAG_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [4:0] run_inc;
    logic       rd_flag;
    s_nxt   = s_r;
    run_inc = RUN_ONE;
    rd_flag = 1'b0;
    s_nxt.div = s_r.div + 7'h01;

    // per-input detection; a read arms, a write of 0 clears, set wins
    for (int i = 0; i < N_IN; i++) begin
      if (do_write && widx == IDX_IN_BASE + 6'(i)) begin
        s_nxt.ictl[i] = (s_r.ictl[i] & ~(wmask & IN_WR_MASK)) | (wval & wmask & IN_WR_MASK);
        if (s_r.arm[i] && wmask[FLAG_BIT] && !wval[FLAG_BIT]) begin
          s_nxt.ictl[i][FLAG_BIT] = 1'b0;
          s_nxt.arm[i]            = 1'b0;
        end
      end
      s_nxt.prev[i] = req_n[i];
      run_inc = s_r.run[i] + RUN_ONE;  // five bits hold a run of 16 without wrapping
      if (s_r.ictl[i][MODE_LSB+:4] == MODE_EDGE) begin
        s_nxt.run[i] = '0;
        if (s_r.prev[i] && !req_n[i]) begin
          s_nxt.ictl[i][FLAG_BIT] = 1'b1;
        end
      end else if (level_tick(s_r.ictl[i][MODE_LSB+:4], s_r.div)) begin
        if (req_n[i]) begin
          s_nxt.run[i] = '0;
        end else if (run_inc >= run_need(s_r.ictl[i][SCNT_LSB+:4])) begin
          s_nxt.run[i]            = '0;
          s_nxt.ictl[i][FLAG_BIT] = 1'b1;
        end else begin
          s_nxt.run[i] = run_inc;
        end
      end
    end

    // output compare, oscillator, comparator and software stop registers
    if (do_write && widx == IDX_OCMP) begin
      s_nxt.ocmp = (s_r.ocmp & ~(wmask & OC_WR_MASK)) | (wval & wmask & OC_WR_MASK);
      if (s_r.marm[0] && wmask[OC_MTU_F] && !wval[OC_MTU_F]) begin
        s_nxt.ocmp[OC_MTU_F] = 1'b0;
        s_nxt.marm[0]        = 1'b0;
      end
      if (s_r.marm[1] && wmask[OC_GPT_F] && !wval[OC_GPT_F]) begin
        s_nxt.ocmp[OC_GPT_F] = 1'b0;
        s_nxt.marm[1]        = 1'b0;
      end
    end
    if (do_write && widx == IDX_MISC) begin
      s_nxt.misc = (s_r.misc & ~(wmask & MI_WR_MASK)) | (wval & wmask & MI_WR_MASK);
      if (s_r.marm[2] && wmask[MI_OSC_F] && !wval[MI_OSC_F]) begin
        s_nxt.misc[MI_OSC_F] = 1'b0;
        s_nxt.marm[2]        = 1'b0;
      end
      if (s_r.marm[3] && wmask[MI_CMP_F] && !wval[MI_CMP_F]) begin
        s_nxt.misc[MI_CMP_F] = 1'b0;
        s_nxt.marm[3]        = 1'b0;
      end
    end
    if (do_write && widx == IDX_SWSTOP && s_r.wstrb[0]) begin
      s_nxt.sw_stop = s_r.wdata[0];
    end
    // event sets come after the clears so a coincident event survives
    if (s_r.ocmp[OC_MTU_EN] && |(pwm_levels.mtu_first & pwm_levels.mtu_second)) begin
      s_nxt.ocmp[OC_MTU_F] = 1'b1;
    end
    if (s_r.ocmp[OC_GPT_EN] && |(pwm_levels.gpt_a & pwm_levels.gpt_b)) begin
      s_nxt.ocmp[OC_GPT_F] = 1'b1;
    end
    if (s_r.misc[MI_OSC_EN] && osc_stopped) begin
      s_nxt.misc[MI_OSC_F] = 1'b1;
    end
    if (s_r.misc[MI_CMP_EN] && analog_comparator) begin
      s_nxt.misc[MI_CMP_F] = 1'b1;
    end

    // write channel: address and data in either order, response after both
    if (awvalid && s_r.awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = awaddr;
    end
    if (wvalid && s_r.wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = wdata;
      s_nxt.wstrb = wstrb;
    end
    if (do_write) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = (widx <= IDX_SWSTOP) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end

    // read channel; a read that shows a flag arms its clear
    if (arvalid && s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = RESP_OKAY;
      s_nxt.rdata  = '0;
      if (ridx < IDX_OCMP) begin
        s_nxt.rdata[15:0] = s_r.ictl[ridx[3:0]];
        rd_flag           = s_r.ictl[ridx[3:0]][FLAG_BIT];
        if (rd_flag) begin
          s_nxt.arm[ridx[3:0]] = 1'b1;
        end
      end else if (ridx == IDX_OCMP) begin
        s_nxt.rdata[15:0] = s_r.ocmp;
        s_nxt.marm[1:0]   = s_r.marm[1:0] | {s_r.ocmp[OC_GPT_F], s_r.ocmp[OC_MTU_F]};
      end else if (ridx == IDX_MISC) begin
        s_nxt.rdata[15:0] = s_r.misc;
        s_nxt.marm[3:2]   = s_r.marm[3:2] | {s_r.misc[MI_CMP_F], s_r.misc[MI_OSC_F]};
      end else if (ridx == IDX_SWSTOP) begin
        s_nxt.rdata[0] = s_r.sw_stop;
      end else begin
        s_nxt.rresp = RESP_SLVERR;
      end
    end else if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
    s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
    s_nxt.wready  = !s_nxt.w_got && !s_nxt.bvalid;
    s_nxt.arready = !s_nxt.rvalid;

    // any latched cause keeps the pins stopped until software clears it
    s_nxt.pin_stop  = (|in_flags) || s_r.ocmp[OC_MTU_F] || s_r.ocmp[OC_GPT_F]
                      || s_r.misc[MI_OSC_F] || s_r.misc[MI_CMP_F] || s_r.sw_stop;
    s_nxt.port_mode = s_r.misc[MI_PORT_MD];
    s_nxt.irq_in = 1'b0;
    for (int i = 0; i < N_IN; i++) begin
      if (s_r.ictl[i][FLAG_BIT] && s_r.ictl[i][IEN_BIT]) begin
        s_nxt.irq_in = 1'b1;
      end
    end
    s_nxt.irq_out = s_r.ocmp[OC_IEN] && (s_r.ocmp[OC_MTU_F] || s_r.ocmp[OC_GPT_F]);
  end

  //////////////////////////////////////////////////////////////////////////////
  // register stage

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign awready    = s_r.awready;
  assign wready     = s_r.wready;
  assign bvalid     = s_r.bvalid;
  assign bresp      = s_r.bresp;
  assign arready    = s_r.arready;
  assign rvalid     = s_r.rvalid;
  assign rdata      = s_r.rdata;
  assign rresp      = s_r.rresp;
  assign pin_stop   = s_r.pin_stop;
  assign port_mode  = s_r.port_mode;
  assign irq_input  = s_r.irq_in;
  assign irq_output = s_r.irq_out;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_edge_accept: assert property (s_r.ictl[0][MODE_LSB+:4] == MODE_EDGE && s_r.prev[0] && !req_n[0]
                                  |=> s_r.ictl[0][FLAG_BIT]) else $error("edge not accepted");
  a_run_restart: assert property (s_r.ictl[0][MODE_LSB+:4] == MODE_DIV1 && req_n[0]
                                  |=> s_r.run[0] == '0) else $error("low run not restarted");
  a_four_lows: assert property (s_r.ictl[2][MODE_LSB+:4] == MODE_DIV1 && s_r.ictl[2][SCNT_LSB+:4] == SCNT_SEL4
                                && !s_r.ictl[2][FLAG_BIT] && s_r.run[2] == '0 && !req_n[2] ##1 !req_n[2] [*3]
                                |=> s_r.ictl[2][FLAG_BIT]) else $error("four lows not accepted");
  a_flag_sticky: assert property (s_r.ictl[0][FLAG_BIT] && !s_r.arm[0]
                                  |=> s_r.ictl[0][FLAG_BIT]) else $error("flag lost without read");
  a_stop_inputs: assert property (|in_flags |=> pin_stop) else $error("input flag did not stop");
  a_sw_stop: assert property (s_r.sw_stop |=> pin_stop) else $error("software stop ignored");
  a_mtu_short: assert property (s_r.ocmp[OC_MTU_EN] && |(pwm_levels.mtu_first & pwm_levels.mtu_second)
                                |=> ##1 pin_stop) else $error("mtu short missed");
  a_gpt_short: assert property (s_r.ocmp[OC_GPT_EN] && |(pwm_levels.gpt_a & pwm_levels.gpt_b)
                                |=> ##1 pin_stop) else $error("gpt short missed");
  a_osc_stop: assert property (s_r.misc[MI_OSC_EN] && osc_stopped
                               |=> s_r.misc[MI_OSC_F]) else $error("osc missed");
  a_cmp_stop: assert property (s_r.misc[MI_CMP_EN] && analog_comparator
                               |=> ##1 pin_stop) else $error("comparator missed");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bresp dropped");

endmodule : port_output_disable_ctrl

// [rtl/stop_ctrl_pkg.sv]
// constants, register map and carrier types of the output stop controller
package stop_ctrl_pkg;

  // number of external stop request inputs (0,4,8,9,10,11,12,13,14)
  localparam int            N_IN        = 9;
  localparam int            N_MTU_PAIR  = 6;
  localparam int            N_GPT_PAIR  = 9;

  // register word index (byte address = index * 4)
  localparam logic [5:0]    IDX_IN_BASE = 6'h00;   // input0 at 0x00, input4 at 0x04, next inputs follow
  localparam logic [5:0]    IDX_OCMP    = 6'h09;   // output compare control/status, 0x24
  localparam logic [5:0]    IDX_MISC    = 6'h0A;   // oscillator, comparator, pin state, 0x28
  localparam logic [5:0]    IDX_SWSTOP  = 6'h0B;   // software stop request, 0x2C

  // per-input control/status fields
  localparam int            MODE_LSB    = 0;
  localparam int            SCNT_LSB    = 4;
  localparam int            FLAG_BIT    = 12;
  localparam int            IEN_BIT     = 13;
  localparam logic [15:0]   IN_WR_MASK  = 16'h20FF;  // bits that a write stores directly

  // output compare register fields
  localparam int            OC_MTU_EN   = 0;
  localparam int            OC_GPT_EN   = 1;
  localparam int            OC_IEN      = 2;
  localparam int            OC_MTU_F    = 8;
  localparam int            OC_GPT_F    = 9;
  localparam logic [15:0]   OC_WR_MASK  = 16'h0007;

  // misc register fields
  localparam int            MI_OSC_EN   = 0;
  localparam int            MI_CMP_EN   = 1;
  localparam int            MI_PORT_MD  = 2;
  localparam int            MI_OSC_F    = 8;
  localparam int            MI_CMP_F    = 9;
  localparam logic [15:0]   MI_WR_MASK  = 16'h0007;

  // detection mode encodings
  localparam logic [3:0]    MODE_EDGE   = 4'h0;
  localparam logic [3:0]    MODE_DIV8   = 4'h1;
  localparam logic [3:0]    MODE_DIV16  = 4'h2;
  localparam logic [3:0]    MODE_DIV128 = 4'h3;
  localparam logic [3:0]    MODE_DIV1   = 4'h4;
  localparam logic [3:0]    MODE_DIV2   = 4'h5;
  localparam logic [3:0]    MODE_DIV4   = 4'h6;

  // divider masks: a tick when all masked divider bits are ones
  localparam logic [6:0]    MSK_DIV1    = 7'h00;
  localparam logic [6:0]    MSK_DIV2    = 7'h01;
  localparam logic [6:0]    MSK_DIV4    = 7'h03;
  localparam logic [6:0]    MSK_DIV8    = 7'h07;
  localparam logic [6:0]    MSK_DIV16   = 7'h0F;
  localparam logic [6:0]    MSK_DIV128  = 7'h7F;

  // sampling count select encodings and counts
  localparam logic [3:0]    SCNT_SEL16  = 4'h0;
  localparam logic [3:0]    SCNT_SEL8   = 4'h1;
  localparam logic [3:0]    SCNT_SEL4   = 4'h2;
  localparam logic [4:0]    RUN_16      = 5'h10;
  localparam logic [4:0]    RUN_8       = 5'h08;
  localparam logic [4:0]    RUN_4       = 5'h04;
  localparam logic [4:0]    RUN_ONE     = 5'h01;

  localparam logic [1:0]    RESP_OKAY   = 2'h0;
  localparam logic [1:0]    RESP_SLVERR = 2'h2;

  // active levels of the compared timer output pairs
  typedef struct packed {
    logic [N_MTU_PAIR-1:0] mtu_first;   // 3B,4A,4B,6B,7A,7B
    logic [N_MTU_PAIR-1:0] mtu_second;  // 3D,4C,4D,6D,7C,7D
    logic [N_GPT_PAIR-1:0] gpt_a;       // channels 0,1,2,4,5,6,7,8,9
    logic [N_GPT_PAIR-1:0] gpt_b;
  } pwm_levels_s;

  // whole state of the controller
  typedef struct packed {
    logic [N_IN-1:0][15:0] ictl;
    logic [N_IN-1:0]       prev;
    logic [N_IN-1:0][4:0]  run;
    logic [N_IN-1:0]       arm;
    logic [15:0]           ocmp;
    logic [15:0]           misc;
    logic [3:0]            marm;
    logic                  sw_stop;
    logic [6:0]            div;
    logic                  aw_got;
    logic [7:0]            awaddr;
    logic                  w_got;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  awready;
    logic                  wready;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic                  pin_stop;
    logic                  port_mode;
    logic                  irq_in;
    logic                  irq_out;
  } state_s;

endpackage : stop_ctrl_pkg

// [testbench/fault_source_model.sv]
// far-side model: stop request pins, timer output levels, oscillator and comparator
`timescale 1ns/100ps
module fault_source_model
  import stop_ctrl_pkg::*;
(
  // commands from the bench
  input  wire logic [8:0]  low_sel,
  input  wire logic [14:0] short_sel,
  input  wire logic [14:0] half_sel,
  input  wire logic        osc_cmd,
  input  wire logic        cmp_cmd,
  // pins toward the block
  output logic [8:0]       req_n,
  output pwm_levels_s      levels,
  output logic             osc_out,
  output logic             cmp_out
);
  // request pins rest high on their pull-ups, so a release never leaves a stale low
  assign req_n = ~low_sel;
  // a short drives both pins of a pair active, a half drives only the first one
  assign levels = {short_sel[5:0] | half_sel[5:0], short_sel[5:0], short_sel[14:6] | half_sel[14:6], short_sel[14:6]};
  // clock monitor and comparator outputs follow the bench directly
  assign osc_out = osc_cmd;
  assign cmp_out = cmp_cmd;
endmodule : fault_source_model

// [testbench/port_output_disable_ctrl_tb.sv]
// self-checking bench for the output stop controller
`timescale 1ns/100ps
module port_output_disable_ctrl_tb
  import stop_ctrl_pkg::*;
;
  // bus, pin and bookkeeping signals
  logic        aclk, aresetn;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [2:0]  awprot, arprot;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [8:0]  low_sel, req_n;
  logic [14:0] short_sel, half_sel;
  logic        osc_cmd, cmp_cmd, osc_out, cmp_out;
  pwm_levels_s levels;
  logic        pin_stop, port_mode, irq_input, irq_output;
  int          bad_count, checked, cyc;

  port_output_disable_ctrl port_output_disable_ctrl_i (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(awprot),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .stop_req_in_0(req_n[0]), .stop_req_in_4(req_n[1]), .stop_req_in_8(req_n[2]),
    .stop_req_in_9(req_n[3]), .stop_req_in_10(req_n[4]), .stop_req_in_11(req_n[5]),
    .stop_req_in_12(req_n[6]), .stop_req_in_13(req_n[7]), .stop_req_in_14(req_n[8]),
    .pwm_levels(levels), .osc_stopped(osc_out), .analog_comparator(cmp_out),
    .pin_stop(pin_stop), .port_mode(port_mode), .irq_input(irq_input), .irq_output(irq_output)
  );

  fault_source_model fault_source_model_i (
    .low_sel(low_sel), .short_sel(short_sel), .half_sel(half_sel), .osc_cmd(osc_cmd),
    .cmp_cmd(cmp_cmd), .req_n(req_n), .levels(levels), .osc_out(osc_out), .cmp_out(cmp_out)
  );

  ////////////////////////////////////////////////////////////
  // 25 MHz clock
  always #20 aclk = ~aclk;

  // hang guard: the whole run needs well under this many cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic conclude();
    if (bad_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= {16'h0000, d};
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", 32'(er), 32'(bresp));
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rresp", 32'(er), 32'(rresp));
    chk("rdata", exp, rdata);
  endtask : rdchk

  // pin_stop may lag its cause by a couple of edges
  task automatic wait_stop(input logic e, input int lim);
    int n;
    n = 0;
    while (pin_stop !== e && n < lim) begin
      @(posedge aclk);
      n++;
    end
    chk("pin_stop", 32'(e), 32'(pin_stop));
  endtask : wait_stop

  ////////////////////////////////////////////////////////////
  task automatic s_reset();
    chk("idle outputs", 32'h0, {28'h0, pin_stop, port_mode, irq_input, irq_output});
    rdchk(8'h00, 32'h0);
    rdchk(8'h30, 32'h0, RESP_SLVERR);
    wr(8'h30, 16'hFFFF, RESP_SLVERR);
  endtask : s_reset

  task automatic s_edge();
    wr(8'h00, 16'h2000, RESP_OKAY);
    low_sel[0] <= 1'b1;
    wait_stop(1'b1, 4);
    chk("irq_input", 32'h1, 32'(irq_input));
    low_sel[0] <= 1'b0;
    wr(8'h00, 16'h2000, RESP_OKAY);
    rdchk(8'h00, 32'h3000);
    wr(8'h00, 16'h2000, RESP_OKAY);
    rdchk(8'h00, 32'h2000);
    wait_stop(1'b0, 4);
  endtask : s_edge

  // every rate and count across all nine inputs, with a high glitch first
  task automatic s_level();
    logic [3:0] md [9] = '{MODE_DIV1, MODE_DIV2, MODE_DIV1, MODE_DIV8, MODE_DIV16, MODE_DIV128,
                           MODE_DIV4, MODE_DIV2, MODE_DIV4};
    int dv [9] = '{1, 2, 1, 8, 16, 128, 4, 2, 4};
    int n;
    logic [15:0] cfg;
    logic [7:0] a;
    for (int k = 0; k < 9; k++) begin
      n = (k % 3 == 0) ? 16 : (k % 3 == 1) ? 8 : 4;
      cfg = {8'h00, 4'(k % 3), md[k]};
      a = 8'(4 * k);
      wr(a, cfg, RESP_OKAY);
      low_sel[k] <= 1'b1;
      repeat ((n - 1) * dv[k]) @(posedge aclk);
      low_sel[k] <= 1'b0;
      repeat (dv[k]) @(posedge aclk);
      low_sel[k] <= 1'b1;
      repeat ((n - 1) * dv[k]) @(posedge aclk);
      chk("early pin_stop", 32'h0, 32'(pin_stop));
      wait_stop(1'b1, 2 * dv[k] + 4);
      low_sel[k] <= 1'b0;
      rdchk(a, {16'h0000, cfg | 16'h1000});
      wr(a, cfg, RESP_OKAY);
      rdchk(a, {16'h0000, cfg});
      wait_stop(1'b0, 4);
    end
  endtask : s_level

  task automatic s_short();
    wr(8'h24, 16'h0007, RESP_OKAY);
    for (int i = 0; i < 15; i++) begin
      half_sel[i] <= 1'b1;
      repeat (4) @(posedge aclk);
      chk("one-sided pin_stop", 32'h0, 32'(pin_stop));
      half_sel[i]  <= 1'b0;
      short_sel[i] <= 1'b1;
      wait_stop(1'b1, 4);
      chk("irq_output", 32'h1, 32'(irq_output));
      short_sel[i] <= 1'b0;
      rdchk(8'h24, (i < 6) ? 32'h0107 : 32'h0207);
      wr(8'h24, 16'h0007, RESP_OKAY);
      wait_stop(1'b0, 4);
    end
  endtask : s_short

  task automatic s_misc();
    wr(8'h28, 16'h0007, RESP_OKAY);
    @(posedge aclk);                  // port_mode follows the register one edge later
    chk("port_mode", 32'h1, 32'(port_mode));
    for (int j = 0; j < 2; j++) begin
      osc_cmd <= (j == 0);
      cmp_cmd <= (j == 1);
      wait_stop(1'b1, 4);
      osc_cmd <= 1'b0;
      cmp_cmd <= 1'b0;
      rdchk(8'h28, (j == 0) ? 32'h0107 : 32'h0207);
      wr(8'h28, 16'h0007, RESP_OKAY);
      wait_stop(1'b0, 4);
    end
    wr(8'h28, 16'h0000, RESP_OKAY);
    @(posedge aclk);
    chk("port_mode", 32'h0, 32'(port_mode));
    wr(8'h2C, 16'h0001, RESP_OKAY);
    wait_stop(1'b1, 4);
    rdchk(8'h2C, 32'h1);
    wr(8'h2C, 16'h0000, RESP_OKAY);
    wait_stop(1'b0, 4);
  endtask : s_misc

  // a reset in mid-run drops a latched software stop and releases the pins
  task automatic s_midreset();
    wr(8'h2C, 16'h0001, RESP_OKAY);
    wait_stop(1'b1, 4);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("reset pin_stop", 32'h0, 32'(pin_stop));
    rdchk(8'h2C, 32'h0);
    rdchk(8'h00, 32'h0);
  endtask : s_midreset

  // main sequence: quiet inputs, 20-cycle reset, then each scenario
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, awprot, arprot, wdata} = '0;
    wstrb = 4'hF;
    {low_sel, short_sel, half_sel, osc_cmd, cmp_cmd} = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    s_reset();
    s_edge();
    s_level();
    s_short();
    s_misc();
    s_midreset();
    conclude();
  end
endmodule : port_output_disable_ctrl_tb
